// ### hw/dsa_defines.svh
`ifndef DSA_DEFINES_SVH
`define DSA_DEFINES_SVH

// stride register fields
`define DSA_FRM_STRIDE_HI   31
`define DSA_FRM_STRIDE_LO   16
`define DSA_ELE_STRIDE_HI   15
`define DSA_ELE_STRIDE_LO   0
// reset values
`define DSA_STRIDE_RST      32'h0000_0000
`define DSA_PEER_RST        32'h0000_0000
// split destination sits one word above the source
`define DSA_SPLIT_DST_OFS   32'h0000_0004
// peripheral bus timing in core cycles
`define DSA_PB_CPU_SINGLE   4'h5
`define DSA_PB_CPU_PARALLEL 4'h9
`define DSA_PB_DMA_SPACING  4'h3
// number of internal memory banks
`define DSA_NUM_BANKS       4
`define DSA_BANK_W          2
// fifo
`define DSA_FIFO_DEPTH      16
`define DSA_FIFO_AW         4

`endif

// ### hw/dsa_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module dsa_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
	assign out_valid_o = (count_q != '0);
	assign out_data_o  = mem_q[rd_ptr_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
			end
			case ({push, pop})
				2'b10:   count_q <= count_q + (AW+1)'(1);
				2'b01:   count_q <= count_q - (AW+1)'(1);
				default: count_q <= count_q;
			endcase
		end
	end

	property p_no_overflow;
		@(posedge clock_i) disable iff (!rstn_i)
		count_q == (AW+1)'(DEPTH) |-> !in_ready_o;
	endproperty
	a_no_overflow: assert property (p_no_overflow)
		else $error("fifo accepts while full");

endmodule : dsa_fifo

`default_nettype wire

// ### hw/dsa_pkg.sv
`default_nettype none

package dsa_pkg;

	// one requestor's memory access
	typedef struct packed {
		logic        req;
		logic [1:0]  bank;
		logic        wr;
		logic [15:0] wdata;
	} dsa_bank_req_t;

	// a peripheral bus access as issued to the bus
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
		logic        wr;
	} dsa_pb_acc_t;

	typedef enum logic [1:0] {
		DSA_OWN_NONE,
		DSA_OWN_CPU_A,
		DSA_OWN_CPU_B,
		DSA_OWN_DMA
	} dsa_owner_t;

	typedef enum logic [1:0] {
		DSA_PB_IDLE,
		DSA_PB_BUSY
	} dsa_pb_state_t;

endpackage : dsa_pkg

`default_nettype wire

// ### hw/dsa_split_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defines.svh"

// Operation
// - upper half is signed frame stride
// - lower half is signed element stride
// - element stride between, frame stride last
// - channel stride-select picks stride register
// - channel split-select picks peer address
// - split reads come from peer address
// - split writes go peer address plus four
// - cpu path a beats path b
// - rank bit orders dma against cpu
// - banks 16 bits, one access each cycle
// - lower rank stalls until banks free
// - peripheral writes always full word
// - byte reads return whole word
// - peripheral accesses serialized, multicycle
// - cpu stall five single, nine parallel
// - dma peripheral access every three cycles
module dsa_split_arbiter (
	input  wire logic                  clock_i,
	input  wire logic                  rstn_i,
	// register writes from the channel register file
	input  wire logic                  stride_we_i,
	input  wire logic                  stride_sel_wr_i,
	input  wire logic [31:0]           reg_wdata_i,
	input  wire logic                  peer_we_i,
	input  wire logic [1:0]            peer_sel_wr_i,
	input  wire logic                  rd_stride_sel_i,
	input  wire logic [1:0]            rd_peer_sel_i,
	output logic      [31:0]           stride_rdata_o,
	output logic      [31:0]           peer_rdata_o,
	// channel main control fields and address step request
	input  wire logic                  chan_stride_sel_i,
	input  wire logic [1:0]            chan_split_sel_i,
	input  wire logic                  requestor_rank_bit_i,
	input  wire logic                  split_mode_i,
	input  wire logic                  step_i,
	input  wire logic                  step_last_i,
	input  wire logic [31:0]           addr_i,
	output logic      [31:0]           addr_next_o,
	output logic      [31:0]           split_src_o,
	output logic      [31:0]           split_dst_o,
	// internal memory bank requests
	input  wire dsa_pkg::dsa_bank_req_t cpu_a_bank_i,
	input  wire dsa_pkg::dsa_bank_req_t cpu_b_bank_i,
	input  wire dsa_pkg::dsa_bank_req_t dma_bank_i,
	output logic                       cpu_a_bank_gnt_o,
	output logic                       cpu_b_bank_gnt_o,
	output logic                       dma_bank_gnt_o,
	// peripheral bus requests
	input  wire logic                  cpu_a_pb_req_i,
	input  wire logic                  cpu_b_pb_req_i,
	input  wire dsa_pkg::dsa_pb_acc_t   cpu_a_pb_i,
	input  wire dsa_pkg::dsa_pb_acc_t   cpu_b_pb_i,
	input  wire logic                  dma_pb_valid_i,
	output logic                       dma_pb_ready_o,
	input  wire dsa_pkg::dsa_pb_acc_t   dma_pb_i,
	output logic                       cpu_stall_o,
	output logic                       pb_valid_o,
	output dsa_pkg::dsa_pb_acc_t        pb_acc_o,
	input  wire logic [31:0]           pb_rdata_i,
	output logic      [31:0]           pb_rdata_o
);

	logic [31:0] stride_q [2];
	logic [31:0] peer_q [4];
	logic [31:0] stride_sel;
	logic [31:0] step_ext;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stride_q[0] <= `DSA_STRIDE_RST;
			stride_q[1] <= `DSA_STRIDE_RST;
		end else if (stride_we_i) begin
			stride_q[stride_sel_wr_i] <= reg_wdata_i;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 4; i++) begin
				peer_q[i] <= `DSA_PEER_RST;
			end
		end else if (peer_we_i) begin
			peer_q[peer_sel_wr_i] <= reg_wdata_i;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stride_rdata_o <= '0;
			peer_rdata_o   <= '0;
		end else begin
			stride_rdata_o <= stride_q[rd_stride_sel_i];
			peer_rdata_o   <= peer_q[rd_peer_sel_i];
		end
	end

	assign stride_sel = stride_q[chan_stride_sel_i];
	// frame stride on the last element, element stride otherwise
	assign step_ext = step_last_i ?
		{{16{stride_sel[`DSA_FRM_STRIDE_HI]}},
		 stride_sel[`DSA_FRM_STRIDE_HI:`DSA_FRM_STRIDE_LO]} :
		{{16{stride_sel[`DSA_ELE_STRIDE_HI]}},
		 stride_sel[`DSA_ELE_STRIDE_HI:`DSA_ELE_STRIDE_LO]};

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addr_next_o <= '0;
		end else if (step_i) begin
			addr_next_o <= addr_i + step_ext;
		end
	end

	// split addresses; software keeps the low three bits clear
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			split_src_o <= '0;
			split_dst_o <= '0;
		end else if (split_mode_i) begin
			split_src_o <= peer_q[chan_split_sel_i];
			split_dst_o <= peer_q[chan_split_sel_i] + `DSA_SPLIT_DST_OFS;
		end
	end

	// bank arbitration: fixed a over b, dma placed by its rank bit
	logic a_gnt;
	logic b_gnt;
	logic d_gnt;
	logic a_hit_b;
	logic a_hit_d;
	logic b_hit_d;

	assign a_hit_b = cpu_a_bank_i.req & cpu_b_bank_i.req & (cpu_a_bank_i.bank == cpu_b_bank_i.bank);
	assign a_hit_d = cpu_a_bank_i.req & dma_bank_i.req & (cpu_a_bank_i.bank == dma_bank_i.bank);
	assign b_hit_d = cpu_b_bank_i.req & dma_bank_i.req & (cpu_b_bank_i.bank == dma_bank_i.bank);

	always_comb begin
		if (requestor_rank_bit_i) begin
			d_gnt = dma_bank_i.req;
			a_gnt = cpu_a_bank_i.req & !a_hit_d;
			b_gnt = cpu_b_bank_i.req & !b_hit_d & !a_hit_b;
		end else begin
			a_gnt = cpu_a_bank_i.req;
			b_gnt = cpu_b_bank_i.req & !a_hit_b;
			d_gnt = dma_bank_i.req & !a_hit_d & !b_hit_d;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cpu_a_bank_gnt_o <= 1'b0;
			cpu_b_bank_gnt_o <= 1'b0;
			dma_bank_gnt_o   <= 1'b0;
		end else begin
			cpu_a_bank_gnt_o <= a_gnt;
			cpu_b_bank_gnt_o <= b_gnt;
			dma_bank_gnt_o   <= d_gnt;
		end
	end

	// dma peripheral accesses queue in a fifo ahead of the bus
	dsa_pkg::dsa_pb_acc_t dq_data;
	logic                 dq_valid;
	logic                 dq_pop;

	dsa_fifo #(
		.WIDTH ($bits(dsa_pkg::dsa_pb_acc_t)),
		.DEPTH (`DSA_FIFO_DEPTH),
		.AW    (`DSA_FIFO_AW)
	) u_dma_q (
		.clock_i     (clock_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (dma_pb_valid_i),
		.in_ready_o  (dma_pb_ready_o),
		.in_data_i   (dma_pb_i),
		.out_valid_o (dq_valid),
		.out_ready_i (dq_pop),
		.out_data_o  (dq_data)
	);

	dsa_pkg::dsa_pb_state_t pb_state_q;
	dsa_pkg::dsa_owner_t    pb_owner_q;
	logic [3:0]             pb_cnt_q;
	logic                   cpu_pend_b_q;
	logic                   cpu_take;
	logic                   dma_take;
	logic                   cpu_want;

	assign cpu_want = cpu_a_pb_req_i | cpu_b_pb_req_i;
	always_comb begin
		cpu_take = 1'b0;
		dma_take = 1'b0;
		if (pb_state_q == dsa_pkg::DSA_PB_IDLE && !cpu_pend_b_q) begin
			if (requestor_rank_bit_i) begin
				dma_take = dq_valid;
				cpu_take = cpu_want & !dq_valid;
			end else begin
				cpu_take = cpu_want;
				dma_take = dq_valid & !cpu_want;
			end
		end
	end
	assign dq_pop = dma_take;

	// one access at a time; cpu parallel pair runs as one nine-cycle stall
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pb_state_q   <= dsa_pkg::DSA_PB_IDLE;
			pb_owner_q   <= dsa_pkg::DSA_OWN_NONE;
			pb_cnt_q     <= 4'h0;
			cpu_pend_b_q <= 1'b0;
			pb_valid_o   <= 1'b0;
			pb_acc_o     <= '0;
			cpu_stall_o  <= 1'b0;
		end else begin
			pb_valid_o <= 1'b0;
			case (pb_state_q)
				dsa_pkg::DSA_PB_IDLE: begin
					if (cpu_take) begin
						pb_state_q <= dsa_pkg::DSA_PB_BUSY;
						pb_valid_o <= 1'b1;
						cpu_stall_o <= 1'b1;
						pb_owner_q <= cpu_a_pb_req_i ? dsa_pkg::DSA_OWN_CPU_A
							: dsa_pkg::DSA_OWN_CPU_B;
						pb_acc_o <= cpu_a_pb_req_i ? cpu_a_pb_i : cpu_b_pb_i;
						pb_acc_o.be <= 4'hf;
						cpu_pend_b_q <= cpu_a_pb_req_i & cpu_b_pb_req_i;
						// cpu count spans the whole stall, which ends on return to idle
						pb_cnt_q <= (cpu_a_pb_req_i & cpu_b_pb_req_i) ?
							`DSA_PB_CPU_PARALLEL : `DSA_PB_CPU_SINGLE;
					end else if (dma_take) begin
						pb_state_q <= dsa_pkg::DSA_PB_BUSY;
						pb_valid_o <= 1'b1;
						pb_owner_q <= dsa_pkg::DSA_OWN_DMA;
						pb_acc_o   <= dq_data;
						pb_acc_o.be <= 4'hf;
						pb_cnt_q   <= `DSA_PB_DMA_SPACING - 4'h1;
					end
				end
				dsa_pkg::DSA_PB_BUSY: begin
					if (cpu_pend_b_q && pb_cnt_q == `DSA_PB_CPU_SINGLE) begin
						pb_valid_o <= 1'b1; // second parallel access, serialized
						pb_acc_o   <= cpu_b_pb_i;
						pb_acc_o.be <= 4'hf;
						pb_owner_q <= dsa_pkg::DSA_OWN_CPU_B;
					end
					if (pb_cnt_q == 4'h1) begin
						pb_state_q   <= dsa_pkg::DSA_PB_IDLE;
						cpu_stall_o  <= 1'b0;
						cpu_pend_b_q <= 1'b0;
					end
					pb_cnt_q <= pb_cnt_q - 4'h1;
				end
				default: pb_state_q <= dsa_pkg::DSA_PB_IDLE;
			endcase
		end
	end

	// whole word returned; requestor picks its bytes
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pb_rdata_o <= '0;
		end else begin
			pb_rdata_o <= pb_rdata_i;
		end
	end

	default clocking cb_core @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	property p_split_dst;
		split_mode_i |=> split_dst_o == split_src_o + `DSA_SPLIT_DST_OFS;
	endproperty
	a_split_dst: assert property (p_split_dst)
		else $error("split destination not one word above source");
	property p_cpu_single;
		$rose(cpu_stall_o) && !cpu_pend_b_q |-> cpu_stall_o [*5] ##1 !cpu_stall_o;
	endproperty
	a_cpu_single: assert property (p_cpu_single)
		else $error("single cpu stall not five cycles");
	property p_cpu_par;
		$rose(cpu_stall_o) && cpu_pend_b_q |-> cpu_stall_o [*8] ##1 cpu_stall_o ##1 !cpu_stall_o;
	endproperty
	a_cpu_par: assert property (p_cpu_par)
		else $error("parallel cpu stall not nine cycles");
	property p_ab;
		a_hit_b |-> !b_gnt && (a_gnt || requestor_rank_bit_i && a_hit_d);
	endproperty
	a_ab: assert property (p_ab)
		else $error("path b beat path a");
	property p_low_dma;
		!requestor_rank_bit_i && a_hit_d |=> !dma_bank_gnt_o;
	endproperty
	a_low_dma: assert property (p_low_dma)
		else $error("low rank dma granted on busy bank");
	property p_dma_above;
		requestor_rank_bit_i && a_hit_d |=> dma_bank_gnt_o && !cpu_a_bank_gnt_o;
	endproperty
	a_dma_above: assert property (p_dma_above)
		else $error("high rank dma lost its bank to the cpu");
	property p_be;
		pb_valid_o |-> pb_acc_o.be == 4'hf && pb_owner_q != dsa_pkg::DSA_OWN_NONE;
	endproperty
	a_be: assert property (p_be)
		else $error("partial peripheral write");
	property p_dma_gap;
		dma_take |=> pb_valid_o ##1 !pb_valid_o [*2];
	endproperty
	a_dma_gap: assert property (p_dma_gap)
		else $error("dma peripheral access spacing short");
	property p_stride;
		step_i && step_last_i |=> addr_next_o == $past(addr_i)
			+ 32'($signed($past(stride_sel[`DSA_FRM_STRIDE_HI:`DSA_FRM_STRIDE_LO])));
	endproperty
	a_stride: assert property (p_stride)
		else $error("frame stride not applied");

endmodule : dsa_split_arbiter

`default_nettype wire

// ### testbench/dsa_pb_model.sv
`timescale 1ns/1ps
`default_nettype none

module dsa_pb_model (
	input  wire logic                 clock_i,
	input  wire logic                 pb_valid_i,
	input  wire dsa_pkg::dsa_pb_acc_t pb_acc_i,
	output logic      [31:0]          pb_rdata_o
);
	// a read is answered with the inverted address; otherwise the word flips every cycle
	initial pb_rdata_o = 32'h5a5a_5a5a;
	always @(posedge clock_i) begin
		if (pb_valid_i && !pb_acc_i.wr) begin
			pb_rdata_o <= ~pb_acc_i.addr;
		end else begin
			pb_rdata_o <= ~pb_rdata_o;
		end
	end
endmodule : dsa_pb_model

`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clock_i, rstn_i, swe, ssel, pwe, rss, css, rank, smode, step, slast;
	logic areq, breq, dval, drdy, stall, pbv, ag, bg, dg;
	logic [1:0] psel, rps, csp;
	logic [31:0] wd, addr, anext, ssrc, sdst, srd, prd, pbi, pbo;
	dsa_pkg::dsa_bank_req_t ab, bb, db;
	dsa_pkg::dsa_pb_acc_t apb, bpb, dpb, pacc;
	int errors, n_checks;

	dsa_split_arbiter DUT (.clock_i(clock_i), .rstn_i(rstn_i), .stride_we_i(swe),
		.stride_sel_wr_i(ssel), .reg_wdata_i(wd), .peer_we_i(pwe), .peer_sel_wr_i(psel),
		.rd_stride_sel_i(rss), .rd_peer_sel_i(rps), .stride_rdata_o(srd), .peer_rdata_o(prd),
		.chan_stride_sel_i(css), .chan_split_sel_i(csp), .requestor_rank_bit_i(rank),
		.split_mode_i(smode), .step_i(step), .step_last_i(slast), .addr_i(addr),
		.addr_next_o(anext), .split_src_o(ssrc), .split_dst_o(sdst), .cpu_a_bank_i(ab),
		.cpu_b_bank_i(bb), .dma_bank_i(db), .cpu_a_bank_gnt_o(ag), .cpu_b_bank_gnt_o(bg),
		.dma_bank_gnt_o(dg), .cpu_a_pb_req_i(areq), .cpu_b_pb_req_i(breq), .cpu_a_pb_i(apb),
		.cpu_b_pb_i(bpb), .dma_pb_valid_i(dval), .dma_pb_ready_o(drdy), .dma_pb_i(dpb),
		.cpu_stall_o(stall), .pb_valid_o(pbv), .pb_acc_o(pacc), .pb_rdata_i(pbi),
		.pb_rdata_o(pbo));
	dsa_pb_model far (.clock_i(clock_i), .pb_valid_i(pbv), .pb_acc_i(pacc), .pb_rdata_o(pbi));

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc

	function automatic dsa_pkg::dsa_bank_req_t mk(input logic r, input logic [1:0] b);
		mk = '0;
		mk.req = r;
		mk.bank = b;
	endfunction : mk

	task automatic wr_reg(input logic is_peer, input logic [1:0] sel, input logic [31:0] v);
		swe = !is_peer;
		pwe = is_peer;
		ssel = sel[0];
		psel = sel;
		wd = v;
		cyc(1);
		swe = 1'b0;
		pwe = 1'b0;
		cyc(1);
	endtask : wr_reg

	task automatic t_regs;
		chk("stride reset", srd, 32'h0);
		chk("peer reset", prd, 32'h0);
		wr_reg(1'b0, 2'h0, 32'h8000_0003);
		wr_reg(1'b0, 2'h1, 32'h0010_fffe);
		for (int i = 0; i < 4; i++)
			wr_reg(1'b1, i[1:0], 32'h1000 + 32'(i * 16));
		for (int i = 0; i < 4; i++) begin
			rss = i[0];
			rps = i[1:0];
			cyc(1);
			chk("peer readback", prd, 32'h1000 + 32'(i * 16));
			if (i < 2)
				chk("stride readback", srd, i[0] ? 32'h0010_fffe : 32'h8000_0003);
		end
	endtask : t_regs

	task automatic do_step(input logic sel, input logic last, input logic [31:0] a,
		input logic [31:0] exp);
		css = sel;
		slast = last;
		addr = a;
		step = 1'b1;
		cyc(1);
		step = 1'b0;
		chk("next address", anext, exp);
		cyc(1);
	endtask : do_step

	task automatic t_split;
		for (int i = 0; i < 4; i++) begin
			csp = i[1:0];
			smode = 1'b1;
			cyc(2);
			chk("split source", ssrc, 32'h1000 + 32'(i * 16));
			chk("split destination", sdst, 32'h1004 + 32'(i * 16));
		end
		smode = 1'b0;
	endtask : t_split

	task automatic t_bank;
		ab = mk(1'b1, 2'h1);
		bb = mk(1'b1, 2'h1);
		db = mk(1'b1, 2'h2);
		rank = 1'b0;
		cyc(2);
		chk("grant a", 32'(ag), 32'h1);
		chk("grant b", 32'(bg), 32'h0);
		chk("grant dma other bank", 32'(dg), 32'h1);
		bb = mk(1'b0, 2'h0);
		db = mk(1'b1, 2'h1);
		rank = 1'b1;
		cyc(2);
		chk("grant dma above", 32'(dg), 32'h1);
		chk("grant a below", 32'(ag), 32'h0);
		rank = 1'b0;
		cyc(2);
		chk("grant a above", 32'(ag), 32'h1);
		chk("grant dma below", 32'(dg), 32'h0);
		ab = mk(1'b0, 2'h0);
		db = mk(1'b0, 2'h0);
		cyc(1);
	endtask : t_bank

	task automatic t_cpu(input logic par);
		int n;
		int p;
		logic seen;
		n = 0;
		p = 0;
		seen = 1'b0;
		apb = '{addr: 32'h40, wdata: 32'h12, be: 4'h1, wr: 1'b1};
		bpb = '{addr: 32'h80, wdata: 32'h0, be: 4'h2, wr: 1'b0};
		areq = 1'b1;
		breq = par;
		repeat (30) begin
			@(negedge clock_i);
			if (pbv === 1'b1) begin
				p++;
				chk("byte enables", {28'h0, pacc.be}, 32'hf);
			end
			if (pbo === ~32'h80)
				seen = 1'b1;
			if (stall === 1'b1)
				n++;
			else if (n > 0)
				break;
		end
		areq = 1'b0;
		breq = 1'b0;
		chk("stall cycles", 32'(n), par ? 32'h9 : 32'h5);
		chk("bus accesses", 32'(p), par ? 32'h2 : 32'h1);
		if (par)
			chk("read word", 32'(seen), 32'h1);
		cyc(2);
	endtask : t_cpu

	task automatic t_dma;
		int pushed;
		int got;
		int last;
		int bad;
		logic full;
		pushed = 0;
		got = 0;
		last = 0;
		bad = 0;
		full = 1'b0;
		rank = 1'b1;
		dpb = '{addr: 32'h200, wdata: 32'h77, be: 4'h3, wr: 1'b1};
		dval = 1'b1;
		for (int t = 0; t < 400 && (!full || got < pushed); t++) begin
			if (pbv === 1'b1) begin
				got++;
				if (got > 1 && t - last != 3)
					bad++;
				last = t;
				chk("dma word", pacc.wdata, 32'h77);
				chk("dma address", pacc.addr, 32'h200);
			end
			if (dval && drdy !== 1'b1) begin
				full = 1'b1;
				dval = 1'b0;
			end else if (dval)
				pushed++;
			@(negedge clock_i);
		end
		chk("fifo refused when full", 32'(full), 32'h1);
		chk("all drained", 32'(got), 32'(pushed));
		chk("dma spacing", 32'(bad), 32'h0);
		chk("fifo ready again", 32'(drdy), 32'h1);
	endtask : t_dma

	initial begin
		#(20 * 5000);
		errors++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		errors = 0;
		n_checks = 0;
		{rstn_i, swe, ssel, pwe, rss, css, rank, smode, step, slast, areq, breq, dval} = '0;
		{psel, rps, csp, wd, addr} = '0;
		{ab, bb, db, apb, bpb, dpb} = '0;
		repeat (12) @(negedge clock_i);
		rstn_i = 1'b1;
		cyc(2);
		t_regs();
		do_step(1'b1, 1'b0, 32'h1, 32'hffff_ffff);
		do_step(1'b1, 1'b1, 32'h1, 32'h11);
		do_step(1'b0, 1'b1, 32'h100, 32'hffff_8100);
		do_step(1'b0, 1'b0, 32'hffff_fffe, 32'h1);
		t_split();
		t_bank();
		t_cpu(1'b0);
		t_cpu(1'b1);
		t_dma();
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
